// File: logic/pst_pkg.sv
package pst_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_IIN = 8'h89;
    localparam logic [7:0] CMD_VOUT = 8'h8b;
    localparam logic [7:0] CMD_IOUT = 8'h8c;
    localparam logic [7:0] CMD_TEMP = 8'h8d;
    localparam logic [7:0] CMD_FREQ = 8'h95;
    localparam logic [7:0] CMD_SPEC_REV = 8'h98;
    localparam logic [7:0] CMD_MAKER_ID = 8'h99;
    localparam logic [7:0] CMD_MODEL = 8'h9a;
    localparam logic [7:0] CMD_MAKER_REV = 8'h9b;
    localparam logic [7:0] CMD_SERIAL = 8'h9e;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

    // ------------------------------------------------------------
    // Field layouts and fixed values
    // ------------------------------------------------------------
    localparam int COMM_UNSUP_BIT = 7;
    localparam int COMM_BADDATA_BIT = 6;
    localparam int COMM_PEC_BIT = 5;
    localparam logic [7:0] COMM_IMPL_MASK = 8'he0;
    localparam logic [7:0] VENDOR_IMPL_MASK = 8'hfe;
    localparam int SUMMARY_COMM_BIT = 1;
    localparam logic [4:0] EXP_VIN = 5'h1b;
    localparam logic [4:0] EXP_CURRENT = 5'h1c;
    localparam logic [4:0] EXP_VOUT = 5'h17;
    localparam logic [4:0] EXP_UNITY = 5'h00;
    localparam logic [7:0] SPEC_REV_VALUE = 8'h33;
    localparam logic [7:0] BLOCK_COUNT = 8'h01;
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int NUM_ID = 4;

    // Host request toward the register bank
    typedef struct packed {
        logic valid;
        logic write;
        logic block;
        logic [7:0] code;
        logic [7:0] count;
        logic [7:0] data;
        logic pec_bad;
    } pst_req_t;

    // Answer toward the protocol engine
    typedef struct packed {
        logic valid;
        logic ack;
        logic [7:0] lo;
        logic [7:0] hi;
    } pst_rsp_t;

    // Raw telemetry samples from the measurement path
    typedef struct packed {
        logic [10:0] vin;
        logic [10:0] iin;
        logic [15:0] vout;
        logic [10:0] iout;
        logic [10:0] temp;
        logic [10:0] freq;
    } pst_tele_t;
endpackage : pst_pkg

// File: logic/pst_regs.sv
module pst_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host command port from the protocol engine
    input wire pst_pkg::pst_req_t req,
    output pst_pkg::pst_rsp_t rsp,
    // Measurement path and converter state
    input wire pst_pkg::pst_tele_t tele,
    input wire logic tele_strobe,
    input wire logic regulating_raw,
    // Vendor fault events, bit 7..1 of the vendor byte
    input wire logic [7:1] vendor_event,
    // Alert masks for the two status bytes
    input wire logic [7:0] comm_alert_mask,
    input wire logic [7:0] vendor_alert_mask,
    // Nonvolatile store port
    output logic nv_store,
    output logic [31:0] nv_data,
    // Status summary and alert
    output logic summary_comm,
    output logic host_alert_output_n
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic reg_s1;
    logic regulating;
    logic [7:0] comm_status;
    logic [7:0] vendor_status;
    pst_pkg::pst_tele_t snap;
    logic [7:0] id_val [pst_pkg::NUM_ID];
    logic [1:0] id_sel;
    logic id_hit;
    logic ro_hit;
    logic gated_hit;
    logic known;
    logic wr_unsup;
    logic wr_bad;
    logic [15:0] next_word;
    logic next_ack;

    // Regulating level arrives from the analog side
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_s1 <= 1'b0;
            regulating <= 1'b0;
        end else begin
            reg_s1 <= regulating_raw;
            regulating <= reg_s1;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Identity codes map onto a four entry array
    always_comb begin
        id_hit = 1'b1;
        id_sel = 2'd0;
        case (req.code)
            pst_pkg::CMD_MAKER_ID: id_sel = 2'd0;
            pst_pkg::CMD_MODEL: id_sel = 2'd1;
            pst_pkg::CMD_MAKER_REV: id_sel = 2'd2;
            pst_pkg::CMD_SERIAL: id_sel = 2'd3;
            default: id_hit = 1'b0;
        endcase
    end

    // Read-only codes and those gated by regulation
    always_comb begin
        case (req.code)
            pst_pkg::CMD_COMM_STATUS, pst_pkg::CMD_VENDOR_STATUS,
            pst_pkg::CMD_VIN, pst_pkg::CMD_IIN, pst_pkg::CMD_VOUT,
            pst_pkg::CMD_IOUT, pst_pkg::CMD_TEMP, pst_pkg::CMD_FREQ,
            pst_pkg::CMD_SPEC_REV: ro_hit = 1'b1;
            default: ro_hit = 1'b0;
        endcase
        gated_hit = (req.code == pst_pkg::CMD_IIN) || (req.code == pst_pkg::CMD_VOUT) ||
            (req.code == pst_pkg::CMD_IOUT) || (req.code == pst_pkg::CMD_FREQ);
        known = ro_hit || id_hit || (req.code == pst_pkg::CMD_STORE_ALL) ||
            (req.code == pst_pkg::CMD_CLEAR_FAULTS);
    end

    // Write classification
    always_comb begin
        wr_unsup = req.valid && req.write && !req.pec_bad && (!known || ro_hit);
        wr_bad = req.valid && req.write && !req.pec_bad && id_hit &&
            (!req.block || req.count != pst_pkg::BLOCK_COUNT);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        next_word = 16'h0000;
        next_ack = 1'b1;
        case (req.code)
            pst_pkg::CMD_COMM_STATUS: next_word = {8'h00, comm_status & pst_pkg::COMM_IMPL_MASK};
            pst_pkg::CMD_VENDOR_STATUS:
                next_word = {8'h00, vendor_status & pst_pkg::VENDOR_IMPL_MASK};
            pst_pkg::CMD_VIN: next_word = {pst_pkg::EXP_VIN, snap.vin};
            pst_pkg::CMD_IIN: next_word = {pst_pkg::EXP_CURRENT, snap.iin};
            pst_pkg::CMD_VOUT: next_word = snap.vout;
            pst_pkg::CMD_IOUT: next_word = {pst_pkg::EXP_CURRENT, snap.iout};
            pst_pkg::CMD_TEMP: next_word = {pst_pkg::EXP_UNITY, snap.temp};
            pst_pkg::CMD_FREQ: next_word = {pst_pkg::EXP_UNITY, snap.freq};
            pst_pkg::CMD_SPEC_REV: next_word = {8'h00, pst_pkg::SPEC_REV_VALUE};
            pst_pkg::CMD_MAKER_ID, pst_pkg::CMD_MODEL, pst_pkg::CMD_MAKER_REV,
            pst_pkg::CMD_SERIAL: next_word = {id_val[id_sel], pst_pkg::BLOCK_COUNT};
            default: next_ack = 1'b0;
        endcase
        if (gated_hit && !regulating) begin
            next_ack = 1'b0;
        end
        if (req.write) begin
            next_ack = !wr_unsup && !wr_bad && !req.pec_bad;
            next_word = 16'h0000;
        end
        // Bad PEC refuses reads as well as writes
        if (req.pec_bad) begin
            next_ack = 1'b0;
        end
    end

    // Answer registered one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.ack <= req.valid && next_ack;
            rsp.lo <= next_word[7:0];
            rsp.hi <= next_word[15:8];
        end
    end

    // ------------------------------------------------------------
    // Telemetry snapshot
    // ------------------------------------------------------------
    // Whole sample taken at once so a read never mixes two samples
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap <= '0;
        end else if (tele_strobe) begin
            snap <= tele;
        end
    end

    // ------------------------------------------------------------
    // Identity registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < pst_pkg::NUM_ID; i++) begin
                id_val[i] <= pst_pkg::ID_RESET;
            end
        end else if (req.valid && req.write && id_hit && !wr_bad && !req.pec_bad) begin
            id_val[id_sel] <= req.data;
        end
    end

    // Store-all copies value bytes only, count is constant
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nv_store <= 1'b0;
            nv_data <= 32'h0000_0000;
        end else begin
            nv_store <= req.valid && req.write && !req.pec_bad &&
                (req.code == pst_pkg::CMD_STORE_ALL);
            nv_data <= {id_val[3], id_val[2], id_val[1], id_val[0]};
        end
    end

    // ------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------
    // Sticky comm flags; a new event wins over clear-faults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            comm_status <= 8'h00;
        end else begin
            if (req.valid && req.write && !req.pec_bad &&
                    req.code == pst_pkg::CMD_CLEAR_FAULTS) begin
                comm_status <= 8'h00;
            end
            if (req.valid && req.pec_bad) begin
                comm_status[pst_pkg::COMM_PEC_BIT] <= 1'b1;
            end
            if (wr_unsup) begin
                comm_status[pst_pkg::COMM_UNSUP_BIT] <= 1'b1;
            end
            if (wr_bad) begin
                comm_status[pst_pkg::COMM_BADDATA_BIT] <= 1'b1;
            end
        end
    end

    // Sticky vendor flags, cleared by clear-faults, event wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vendor_status <= 8'h00;
        end else begin
            if (req.valid && req.write && !req.pec_bad &&
                    req.code == pst_pkg::CMD_CLEAR_FAULTS) begin
                vendor_status <= {vendor_event, 1'b0};
            end else begin
                vendor_status <= vendor_status | {vendor_event, 1'b0};
            end
        end
    end

    // Summary and alert, mask bit high suppresses the alert
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            summary_comm <= 1'b0;
            host_alert_output_n <= 1'b1;
        end else begin
            summary_comm <= |(comm_status & pst_pkg::COMM_IMPL_MASK);
            host_alert_output_n <=
                !(|(comm_status & ~comm_alert_mask & pst_pkg::COMM_IMPL_MASK) ||
                  |(vendor_status & ~vendor_alert_mask & pst_pkg::VENDOR_IMPL_MASK));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Output current refused idle
    gated_nak_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_IOUT && !regulating
        |=> rsp.valid && !rsp.ack)
        else $error("output current acked while not regulating");
    iin_nak_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_IIN && !regulating |=> !rsp.ack)
        else $error("input current acked while not regulating");
    vout_nak_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_VOUT && !regulating |=> !rsp.ack)
        else $error("output voltage acked while not regulating");
    freq_nak_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_FREQ && !regulating |=> !rsp.ack)
        else $error("frequency acked while not regulating");
    rev_value_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && !req.pec_bad && req.code == pst_pkg::CMD_SPEC_REV
        |=> rsp.ack && rsp.lo == 8'h33)
        else $error("spec revision wrong");
    vin_exp_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_VIN |=> rsp.hi[7:3] == 5'b11011)
        else $error("input voltage exponent wrong");
    iin_exp_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_IIN |=> rsp.hi[7:3] == 5'b11100)
        else $error("input current exponent wrong");
    iout_exp_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_IOUT |=> rsp.hi[7:3] == 5'b11100)
        else $error("output current exponent wrong");
    temp_exp_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_TEMP |=> rsp.hi[7:3] == 5'b00000)
        else $error("temperature exponent wrong");
    freq_exp_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_FREQ |=> rsp.hi[7:3] == 5'b00000)
        else $error("frequency exponent wrong");
    vout_raw_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_VOUT
        |=> {rsp.hi, rsp.lo} == $past(snap.vout))
        else $error("output voltage word not the snapshot");
    comm_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_COMM_STATUS |=> rsp.lo[4:0] == 5'h00)
        else $error("comm status low bits not zero");
    vendor_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_VENDOR_STATUS
        |=> rsp.lo[0] == 1'b0 && rsp.hi == 8'h00)
        else $error("vendor status bit 0 not zero");
    pec_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && req.pec_bad |=> comm_status[5] && rsp.valid && !rsp.ack)
        else $error("bad PEC not flagged");
    bad_count_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && req.write && !req.pec_bad && req.code == pst_pkg::CMD_MAKER_ID &&
        req.count != 8'h01 |=> comm_status[6] && !rsp.ack)
        else $error("bad block count not flagged");
    ro_write_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && req.write && !req.pec_bad && req.code == pst_pkg::CMD_VIN
        |=> comm_status[7] ##1 summary_comm)
        else $error("read-only write not flagged");
    ro_nak_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && req.write && !req.pec_bad && ro_hit |=> rsp.valid && !rsp.ack)
        else $error("read-only write acked");
    comm_summary_a: assert property (@(posedge clk) disable iff (!rstn)
        comm_status[7:5] != 3'b000 |=> summary_comm)
        else $error("summary bit not set");
    block_cnt_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && !req.write && req.code == pst_pkg::CMD_SERIAL |=> rsp.lo == 8'h01)
        else $error("block count not one");
    id_store_a: assert property (@(posedge clk) disable iff (!rstn)
        req.valid && req.write && !req.pec_bad && req.code == pst_pkg::CMD_STORE_ALL
        |=> nv_store && nv_data == {id_val[3], id_val[2], id_val[1], id_val[0]})
        else $error("store-all did not hand over identity bytes");
    vendor_high_a: assert property (@(posedge clk) disable iff (!rstn)
        vendor_event[7] |=> vendor_status[7])
        else $error("vendor bit 7 not latched");
    vendor_low_a: assert property (@(posedge clk) disable iff (!rstn)
        vendor_event[1] |=> vendor_status[1])
        else $error("vendor bit 1 not latched");
    snap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !tele_strobe |=> $stable(snap))
        else $error("snapshot changed without strobe");
    alert_low_a: assert property (@(posedge clk) disable iff (!rstn)
        vendor_status[7] && !vendor_alert_mask[7] |=> !host_alert_output_n)
        else $error("alert not driven");
endmodule : pst_regs

// File: test/pst_host.sv
module pst_host (
    // Clock
    input wire logic clk,
    // Request out, answer back
    output pst_pkg::pst_req_t req,
    input wire pst_pkg::pst_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle request at time zero
    initial begin
        req = '0;
    end

    // count byte travels with value
    // One command: drive on a falling edge, hold across the taking edge, sample the answer
    task automatic xfer(input logic wr, input logic blk, input logic [7:0] code,
                        input logic [7:0] cnt, input logic [7:0] data, input logic pec,
                        output logic ack, output logic [15:0] word);
        pst_pkg::pst_req_t idle;
        @(negedge clk);
        req <= {1'b1, wr, blk, code, cnt, data, pec};
        @(negedge clk);
        // Answer stands only until the next edge, so take it now
        ack = (rsp.valid === 1'b1) ? rsp.ack : 1'bx;
        word = {rsp.hi, rsp.lo};
        // Released fields show garbage, not the last value
        idle = ~req;
        idle.valid = 1'b0;
        req <= idle;
    endtask : xfer
endmodule : pst_host

// File: test/tb_pst_regs.sv
module tb_pst_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, tele_strobe, regulating_raw, nv_store, summary_comm, host_alert_output_n;
    logic [7:1] vendor_event;
    logic [7:0] comm_alert_mask, vendor_alert_mask;
    logic [7:0] id_val [4];
    logic [31:0] nv_data;
    logic a;
    logic [15:0] w;
    pst_pkg::pst_req_t req;
    pst_pkg::pst_rsp_t rsp;
    pst_pkg::pst_tele_t tele, snap;
    int n_fail, checked, cycles;
    localparam logic [7:0] TELE_CODES [6] = '{pst_pkg::CMD_VIN, pst_pkg::CMD_IIN,
        pst_pkg::CMD_VOUT, pst_pkg::CMD_IOUT, pst_pkg::CMD_TEMP, pst_pkg::CMD_FREQ};
    localparam logic [7:0] ID_CODES [4] = '{pst_pkg::CMD_MAKER_ID, pst_pkg::CMD_MODEL,
        pst_pkg::CMD_MAKER_REV, pst_pkg::CMD_SERIAL};
    // Comm fault table: write to read-only, bad block count, bad PEC
    localparam logic [7:0] F_CODE [3] = '{pst_pkg::CMD_VIN, pst_pkg::CMD_MAKER_ID, pst_pkg::CMD_VIN};
    localparam logic [7:0] F_CNT [3] = '{8'h00, 8'h02, 8'h00};
    localparam logic [2:0] F_WR = 3'b111;
    localparam logic [2:0] F_BLK = 3'b010;
    localparam logic [2:0] F_PEC = 3'b001;

    pst_regs uut (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .tele(tele),
        .tele_strobe(tele_strobe), .regulating_raw(regulating_raw),
        .vendor_event(vendor_event), .comm_alert_mask(comm_alert_mask),
        .vendor_alert_mask(vendor_alert_mask), .nv_store(nv_store), .nv_data(nv_data),
        .summary_comm(summary_comm), .host_alert_output_n(host_alert_output_n));
    pst_host host (.clk(clk), .req(req), .rsp(rsp));

    // ------------------------------------------------------------
    // Clock, hang guard, reporting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is a few hundred cycles; far ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check

    // Expected word of a telemetry read, built from the format constants
    function automatic logic [15:0] tele_word(input logic [7:0] c, input pst_pkg::pst_tele_t t);
        case (c)
            pst_pkg::CMD_VIN: return {pst_pkg::EXP_VIN, t.vin};
            pst_pkg::CMD_IIN: return {pst_pkg::EXP_CURRENT, t.iin};
            pst_pkg::CMD_IOUT: return {pst_pkg::EXP_CURRENT, t.iout};
            pst_pkg::CMD_VOUT: return t.vout;
            pst_pkg::CMD_TEMP: return {pst_pkg::EXP_UNITY, t.temp};
            default: return {pst_pkg::EXP_UNITY, t.freq};
        endcase
    endfunction : tele_word

    // In-range measurement values
    task automatic rand_tele();
        tele.vin = 11'($urandom_range(800));
        tele.iin = 11'($urandom_range(1024));
        tele.vout = 16'($urandom_range(2816, 256));
        tele.iout = 11'($urandom_range(1024));
        tele.temp = 11'($urandom_range(215) - 40);
        tele.freq = 11'($urandom_range(2047, 100));
    endtask : rand_tele

    // Check alert and summary after a fault, read the status byte, then clear
    task automatic after_fault(input logic m, input logic [7:0] code, input logic [7:0] exp);
        @(negedge clk);
        check("alert_n", host_alert_output_n, m);
        check("summary_comm", summary_comm, code == pst_pkg::CMD_COMM_STATUS);
        host.xfer(1'b0, 1'b0, code, 8'h00, 8'h00, 1'b0, a, w);
        check("status byte", w[7:0], exp);
        host.xfer(1'b1, 1'b0, pst_pkg::CMD_CLEAR_FAULTS, 8'h00, 8'h00, 1'b0, a, w);
        repeat (2) @(negedge clk);
        check("alert_n idle", host_alert_output_n, 1'b1);
    endtask : after_fault

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        tele_strobe = 1'b0;
        regulating_raw = 1'b0;
        vendor_event = '0;
        comm_alert_mask = 8'h00;
        vendor_alert_mask = 8'h00;
        tele = '0;
        void'($urandom(53));
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        check("alert_n reset", host_alert_output_n, 1'b1);
        host.xfer(1'b0, 1'b0, pst_pkg::CMD_SPEC_REV, 8'h00, 8'h00, 1'b0, a, w);
        check("spec rev", {a, w[7:0]}, 9'h133);
        // Snapshot reads while regulating, then refusals of the four gated codes when not
        for (int it = 0; it < 4; it++) begin
            regulating_raw = 1'b1;
            rand_tele();
            snap = tele;
            tele_strobe = 1'b1;
            @(negedge clk);
            tele_strobe = 1'b0;
            // Fresh values without a strobe must not leak into reads
            rand_tele();
            repeat (4) @(negedge clk);
            foreach (TELE_CODES[k]) begin
                host.xfer(1'b0, 1'b0, TELE_CODES[k], 8'h00, 8'h00, 1'b0, a, w);
                check("tele ack", a, 1'b1);
                check("tele word", w, tele_word(TELE_CODES[k], snap));
            end
            regulating_raw = 1'b0;
            repeat (5) @(negedge clk);
            foreach (TELE_CODES[k]) begin
                host.xfer(1'b0, 1'b0, TELE_CODES[k], 8'h00, 8'h00, 1'b0, a, w);
                check("idle ack", a, TELE_CODES[k] inside {pst_pkg::CMD_VIN, pst_pkg::CMD_TEMP});
            end
        end
        // Comm faults, unmasked with low mask bits set, then masked
        for (int i = 0; i < 3; i++) begin
            for (int m = 0; m < 2; m++) begin
                comm_alert_mask = m[0] ? 8'h80 >> i : 8'h1f;
                host.xfer(F_WR[2-i], F_BLK[2-i], F_CODE[i], F_CNT[i], 8'h5a, F_PEC[2-i], a, w);
                check("fault ack", a, 1'b0);
                after_fault(m[0], pst_pkg::CMD_COMM_STATUS, 8'h80 >> i);
            end
        end
        // Vendor faults, bit 0 mask has no effect
        for (int b = 1; b < 8; b++) begin
            for (int m = 0; m < 2; m++) begin
                vendor_alert_mask = m[0] ? 8'h01 << b : 8'h01;
                vendor_event = 7'(8'h01 << b >> 1);
                @(negedge clk);
                vendor_event = '0;
                @(negedge clk);
                after_fault(m[0], pst_pkg::CMD_VENDOR_STATUS, 8'h01 << b);
            end
        end
        // Identity block writes, read back, store to nonvolatile
        foreach (ID_CODES[i]) begin
            id_val[i] = 8'($urandom);
            host.xfer(1'b1, 1'b1, ID_CODES[i], 8'h01, id_val[i], 1'b0, a, w);
            check("id write ack", a, 1'b1);
            host.xfer(1'b0, 1'b1, ID_CODES[i], 8'h00, 8'h00, 1'b0, a, w);
            check("id read", {a, w}, {1'b1, id_val[i], 8'h01});
        end
        host.xfer(1'b1, 1'b0, pst_pkg::CMD_STORE_ALL, 8'h00, 8'h00, 1'b0, a, w);
        check("nv_store", nv_store, 1'b1);
        check("nv_data", nv_data, {id_val[3], id_val[2], id_val[1], id_val[0]});
        host.xfer(1'b0, 1'b0, 8'h81, 8'h00, 8'h00, 1'b0, a, w);
        check("unknown ack", a, 1'b0);
        stop_test();
    end
endmodule : tb_pst_regs
